//--- bench/pest_link_model.sv
// link partner: upstream receiver giving ping strobes, downstream
// transmitter counting trigger requests. assumes the dut clock.
`timescale 1ns/1ps

module pest_link_model (
  input wire logic clock, // system clock
  input wire logic tx_trigger, // direct trigger request
  input wire logic crossbar_trigger, // trigger via crossbar
  output logic ping_rx, // one-cycle ping received strobe
  output int frames // frames launched downstream
);
  initial ping_rx = 1'b0;

  // either route launches one frame; no busy refusal is modelled.
  // counts from time zero, the bench only uses differences
  always @(posedge clock) begin
    if (tx_trigger || crossbar_trigger) begin
      frames <= frames + 1;
    end
  end

  // gap models a slow link: idle cycles before the strobe
  task automatic send_ping(input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    ping_rx <= 1'b1;
    @(posedge clock);
    ping_rx <= 1'b0;
  endtask
endmodule // pest_link_model

//--- bench/testbench.sv
// testbench for pest_top: registers, lead trigger, node forward and sync.
// assumes pest_link_model on the ping side and small pwm defaults.
`timescale 1ns/1ps
`include "pest_params.svh"

module testbench;
  localparam int P = 40;
  typedef struct {int k; int v; int l;} pest_note_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] addr = 8'h00;
  pest_pkg::pest_word_t wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  pest_pkg::pest_word_t rdata;
  logic ping_rx, tx_trigger, crossbar_trigger, sync_in;
  logic pwm_output_a, pwm_output_b, pwm_compare_c_event;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  int last_c = 0;
  int frames;
  bit watch = 0;
  bit skip = 0;
  bit gap_mode = 0;
  bit rd_seen = 0;
  pest_note_s q[$];
  logic [31:0] q_rd[$];

  always #2.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  pest_top #(.PERIOD_DEF(16'h0028), .DUTY_DEF(16'h0014), .CMPC_DEF(16'h000a)) pest_top_inst (
    .clock(clock), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ping_rx(ping_rx), .tx_trigger(tx_trigger),
    .crossbar_trigger(crossbar_trigger), .sync_in(sync_in), .pwm_output_a(pwm_output_a),
    .pwm_output_b(pwm_output_b), .pwm_compare_c_event(pwm_compare_c_event));

  pest_link_model pest_link_model_inst (.clock(clock), .tx_trigger(tx_trigger),
    .crossbar_trigger(crossbar_trigger), .ping_rx(ping_rx), .frames(frames));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("counts: %0d checked, %0d failures", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_cycle(input string what, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    q_rd.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
  endtask

  task automatic wait_q(input int lim);
    int n;
    n = 0;
    while (q.size() != 0 && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (q.size() != 0) begin
      cmp_cycle("pulse wait", 0, q.size());
      end_sim();
    end
  endtask

  // first pulse after enabling a lead config has an unknown prescaler phase
  task automatic take(input int k);
    pest_note_s n;
    if (skip) begin
      skip = 0;
    end else if (q.size() == 0) begin
      cmp_cycle("unexpected pulse", -1, k);
    end else begin
      n = q.pop_front();
      cmp_cycle("pulse kind", n.k, k);
      cmp_cycle("pulse time", n.v, gap_mode ? cyc - last_c : cyc);
      if (n.l >= 0) cmp_word("event level", n.l, {31'h0, pwm_compare_c_event});
    end
    last_c = cyc;
  endtask

  always @(negedge clock) begin
    if (rd_seen) cmp_word("rdata", q_rd.pop_front(), rdata);
    rd_seen = rd;
    if (watch && tx_trigger === 1'b1) take(0);
    if (watch && crossbar_trigger === 1'b1) take(1);
    if (watch && sync_in === 1'b1) take(2);
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int c, d, m, c0, f0, ha, hb, hc;
    logic [7:0] u;
    static logic [3:0] cfg [4] = '{4'h4, 4'h4, 4'h6, 4'hc};
    static int pn [4] = '{1, 15, 3, 2};
    void'($urandom(32'h954ef583));
    // any address past the map must be ignored on write and read as zero
    u = 8'h20 + 8'($urandom_range(200, 0));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // timebase counts one per clock from reset; sampled at the second edge after release
    rd_reg(`PEST_OFS_STATUS, 32'h1);
    rd_reg(`PEST_OFS_CTRL, 32'h4);
    rd_reg(`PEST_OFS_PERIOD, 32'h28);
    rd_reg(`PEST_OFS_DUTY_A, 32'h14);
    rd_reg(`PEST_OFS_DUTY_B, 32'h14);
    rd_reg(`PEST_OFS_CMPC, 32'ha);
    rd_reg(`PEST_OFS_PRESC, 32'h1);
    rd_reg(`PEST_OFS_MATCH, 32'h1);
    rd_reg(u, 32'h0);
    wr_reg(`PEST_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clock);
    watch = 1;
    c = $urandom_range(30, 4);
    d = $urandom_range(38, 2);
    m = $urandom_range(30, 3);
    wr_reg(`PEST_OFS_CMPC, c);
    wr_reg(`PEST_OFS_DUTY_A, d);
    wr_reg(`PEST_OFS_MATCH, m);
    wr_reg(`PEST_OFS_PRESC, 32'hfffffff3);
    wr_reg(u, 32'hffffffff);
    rd_reg(`PEST_OFS_CMPC, c);
    rd_reg(`PEST_OFS_DUTY_A, d);
    rd_reg(`PEST_OFS_MATCH, m);
    rd_reg(`PEST_OFS_PRESC, 32'h3);
    rd_reg(u, 32'h0);
    $display("register test done");
    gap_mode = 1;
    for (int i = 0; i < 4; i++) begin
      wr_reg(`PEST_OFS_PRESC, pn[i]);
      skip = 1;
      repeat (3) q.push_back('{cfg[i][3], pn[i] * P, !cfg[i][1]});
      wr_reg(`PEST_OFS_CTRL, cfg[i]);
      if (i == 0) begin
        pest_link_model_inst.send_ping(1);
        repeat (P) @(posedge clock);
        ha = 0;
        hb = 0;
        hc = 0;
        repeat (P) begin
          @(negedge clock);
          ha += (pwm_output_a === 1'b1);
          hb += (pwm_output_b === 1'b1);
          hc += (pwm_compare_c_event === 1'b1);
        end
        cmp_cycle("duty a cycles", d, ha);
        cmp_cycle("duty b cycles", 20, hb);
        cmp_cycle("compare c cycles", P - c, hc);
      end
      wait_q(4 * pn[i] * P + 100);
      wr_reg(`PEST_OFS_CTRL, 32'h0);
      repeat (3) @(posedge clock);
      $display("lead test %0d done", i);
    end
    gap_mode = 0;
    f0 = frames;
    wr_reg(`PEST_OFS_CTRL, 32'h1);
    pest_link_model_inst.send_ping(1);
    repeat (m + 8) @(posedge clock);
    wr_reg(`PEST_OFS_CTRL, 32'h5);
    pest_link_model_inst.send_ping(0);
    c0 = cyc;
    q.push_back('{0, c0 + 2, -1});
    pest_link_model_inst.send_ping(m - 3);
    c0 = cyc;
    q.push_back('{0, c0 + 2, -1});
    q.push_back('{2, c0 + m + 2, -1});
    wait_q(m + 20);
    repeat (m + 4) @(posedge clock);
    $display("node restart test done");
    wr_reg(`PEST_OFS_CTRL, 32'hd);
    pest_link_model_inst.send_ping(2);
    c0 = cyc;
    q.push_back('{1, c0 + 2, -1});
    q.push_back('{2, c0 + m + 5, -1});
    @(posedge clock);
    @(posedge clock);
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    wait_q(m + 20);
    repeat (m + 4) @(posedge clock);
    cmp_cycle("frames sent", 3, frames - f0);
    $display("node crossbar test done");
    end_sim();
  end
endmodule // testbench

//--- include/pest_params.svh
// constants for the ping event sync trigger: register map, field positions,
// reset values and clock figures. definitions only, no logic.
`ifndef PEST_PARAMS_SVH
`define PEST_PARAMS_SVH

// clock and modulator timing
`define PEST_CLK_HZ 200000000
`define PEST_PWM_HZ 20000
`define PEST_DUTY_PCT 50

// register byte offsets
`define PEST_OFS_CTRL 8'h00
`define PEST_OFS_PERIOD 8'h04
`define PEST_OFS_DUTY_A 8'h08
`define PEST_OFS_DUTY_B 8'h0c
`define PEST_OFS_CMPC 8'h10
`define PEST_OFS_PRESC 8'h14
`define PEST_OFS_MATCH 8'h18
`define PEST_OFS_STATUS 8'h1c

// control register fields
`define PEST_CTRL_NODE 0
`define PEST_CTRL_FALL 1
`define PEST_CTRL_EN 2
`define PEST_CTRL_XBAR 3
`define PEST_CTRL_W 4

// status register fields
`define PEST_STAT_BUSY 16
`define PEST_STAT_PCNT_LO 17

// reset values
`define PEST_CTRL_RST 4'h4
`define PEST_PRESC_RST 4'h1
`define PEST_MATCH_RST 16'h0001

`endif

//--- include/pest_pkg.sv
// types shared by the ping event sync trigger design files.
// assumes nothing of its surroundings.
package pest_pkg;

  typedef enum logic [1:0] {
    dly_idle = 2'b01,
    dly_run = 2'b10
  } pest_dly_state_e;

  typedef logic [31:0] pest_word_t;

endpackage

//--- rtl/pest_delay.sv
// node sync delay counter: waits for a start strobe, counts to the match
// value, then gives one sync pulse. assumes start comes from the same clock.
`timescale 1ns/1ps

module pest_delay #(
  parameter int W = 16
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic start, // ping received strobe, already gated
  input wire logic [W-1:0] match, // delay in cycles
  output logic sync_pulse, // one-cycle sync-in pulse
  output logic [W-1:0] count, // running count
  output logic busy // counter is running
);

  generate
    if (W < 2) begin : g_bad_w
      $error("pest_delay: W must be at least 2");
    end
  endgenerate

  pest_pkg::pest_dly_state_e state_r;
  logic [W-1:0] cnt_r;
  logic pulse_r;

  ////////////////////////////////////////////////////////////////////////////
  // state machine and counter

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= pest_pkg::dly_idle;
      cnt_r <= '0;
    end else if (ce) begin
      case (state_r)
        pest_pkg::dly_idle: begin
          cnt_r <= '0;
          if (start) begin // see RQ5
            state_r <= pest_pkg::dly_run;
          end
        end
        pest_pkg::dly_run: begin
          // a fresh strobe wins over the match so the newest ping sets timing
          if (start) begin // see RQ11
            cnt_r <= '0;
          end else if (cnt_r == match) begin // see RQ9
            cnt_r <= '0;
            state_r <= pest_pkg::dly_idle;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= pest_pkg::dly_idle;
          cnt_r <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_r <= 1'b0;
    end else if (ce) begin
      pulse_r <= (state_r == pest_pkg::dly_run) && !start && (cnt_r == match); // see RQ5
    end
  end

  assign sync_pulse = pulse_r;
  assign count = cnt_r;
  assign busy = (state_r == pest_pkg::dly_run);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dcb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_reach_match;
    ce && busy && !start && (cnt_r == match);
  endsequence

  a_pulse_at_match: assert property (s_reach_match |=> pulse_r && !busy) // see RQ5
    else $error("sync pulse missing at match");
  a_restart_zero: assert property (ce && start |=> busy && cnt_r == '0) // see RQ11
    else $error("start did not restart the count");
  a_pulse_single: assert property (ce && pulse_r |=> !pulse_r) // see RQ11
    else $error("sync pulse longer than one cycle");
  a_pulse_cause: assert property ($rose(pulse_r) |-> $past(busy) && $past(cnt_r) == match) // see RQ9
    else $error("sync pulse without match");

endmodule // pest_delay

//--- rtl/pest_top.sv
// ping event sync trigger: pwm timebase, lead-side compare trigger with
// prescaler, node-side ping forward and delayed sync-in.
// assumes the ping strobe is already on this clock and one cycle long.
//
// Contract
// RQ1: lead requests ping on prescaled compare-c event
// RQ2: prescaler passes every nth event, n up to 15
// RQ3: compare-c threshold is software programmable
// RQ4: programmable period and duties, default 50% 20 kHz
// RQ5: node fsm waits strobe, counts, emits sync-in
// RQ6: node delay match value is programmable
// RQ7: forward trigger goes direct or via crossbar
// RQ8: received ping forwards at once, independent of delay
// RQ9: delay counter restarts from zero at match
// RQ10: lead trigger edge rising or falling, selectable
// RQ11: single-cycle pulses; new strobe restarts delay
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "pest_params.svh"

module pest_top #(
  parameter int CW = 16,
  parameter int PW = 4,
  parameter logic [CW-1:0] PERIOD_DEF = CW'(`PEST_CLK_HZ / `PEST_PWM_HZ),
  parameter logic [CW-1:0] DUTY_DEF = CW'(`PEST_CLK_HZ / `PEST_PWM_HZ * `PEST_DUTY_PCT / 100),
  parameter logic [CW-1:0] CMPC_DEF = CW'(`PEST_CLK_HZ / `PEST_PWM_HZ / 4)
) (
  input wire logic clock, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  input wire logic [7:0] addr, // register byte address
  input wire pest_pkg::pest_word_t wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output pest_pkg::pest_word_t rdata, // read data, cycle after rd
  input wire logic ping_rx, // ping received strobe from serial receiver
  output logic tx_trigger, // direct external trigger to transmitter
  output logic crossbar_trigger, // trigger routed through pwm crossbar
  output logic sync_in, // sync-in pulse to local modulator
  output logic pwm_output_a, // modulator output a
  output logic pwm_output_b, // modulator output b
  output logic pwm_compare_c_event // compare-c event level
);

  generate
    if (CW < 8 || CW > 32 || PW < 4 || PW > 32) begin : g_bad_par
      $error("pest_top: CW must be 8..32 and PW 4..32");
    end
  endgenerate

  logic [`PEST_CTRL_W-1:0] ctrl_r;
  logic [CW-1:0] period_r, duty_a_r, duty_b_r, cmpc_r, match_r;
  logic [PW-1:0] presc_r, presc_cnt_r;
  logic [CW-1:0] cnt_r;
  logic evt_r, evt_prev_r, lead_fire_r, fwd_r, trig_r, xbar_r;
  logic pa_r, pb_r;
  pest_pkg::pest_word_t rdata_r;
  logic dly_pulse, dly_busy;
  logic [CW-1:0] dly_count;
  logic node, en, edge_hit, presc_wrap, dly_start;

  assign node = ctrl_r[`PEST_CTRL_NODE];
  assign en = ctrl_r[`PEST_CTRL_EN];

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `PEST_CTRL_RST;
      period_r <= PERIOD_DEF; // see RQ4
      duty_a_r <= DUTY_DEF;
      duty_b_r <= DUTY_DEF;
      cmpc_r <= CMPC_DEF;
      presc_r <= PW'(`PEST_PRESC_RST);
      match_r <= CW'(`PEST_MATCH_RST);
    end else if (ce && wr) begin
      case (addr)
        `PEST_OFS_CTRL: ctrl_r <= wdata[`PEST_CTRL_W-1:0];
        `PEST_OFS_PERIOD: period_r <= wdata[CW-1:0]; // see RQ4
        `PEST_OFS_DUTY_A: duty_a_r <= wdata[CW-1:0]; // see RQ4
        `PEST_OFS_DUTY_B: duty_b_r <= wdata[CW-1:0]; // see RQ4
        `PEST_OFS_CMPC: cmpc_r <= wdata[CW-1:0]; // see RQ3
        `PEST_OFS_PRESC: presc_r <= wdata[PW-1:0]; // see RQ2
        `PEST_OFS_MATCH: match_r <= wdata[CW-1:0]; // see RQ6
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, data stand one cycle after the strobe only

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= '0;
      if (rd) begin
        case (addr)
          `PEST_OFS_CTRL: rdata_r <= 32'(ctrl_r);
          `PEST_OFS_PERIOD: rdata_r <= 32'(period_r);
          `PEST_OFS_DUTY_A: rdata_r <= 32'(duty_a_r);
          `PEST_OFS_DUTY_B: rdata_r <= 32'(duty_b_r);
          `PEST_OFS_CMPC: rdata_r <= 32'(cmpc_r);
          `PEST_OFS_PRESC: rdata_r <= 32'(presc_r);
          `PEST_OFS_MATCH: rdata_r <= 32'(match_r);
          `PEST_OFS_STATUS: begin
            rdata_r[15:0] <= 16'(cnt_r);
            rdata_r[`PEST_STAT_BUSY] <= dly_busy;
            rdata_r[`PEST_STAT_PCNT_LO +: 4] <= 4'(presc_cnt_r);
          end
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm timebase; a sync-in pulse pulls the counter back to zero so the node
  // lines up with the lead's zero event

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (dly_pulse || cnt_r >= period_r - 1'b1) begin // see RQ4
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pa_r <= 1'b0;
      pb_r <= 1'b0;
      evt_r <= 1'b0;
      evt_prev_r <= 1'b0;
    end else if (ce) begin
      pa_r <= cnt_r < duty_a_r; // see RQ4
      pb_r <= cnt_r < duty_b_r; // see RQ4
      evt_r <= cnt_r >= cmpc_r; // see RQ3
      evt_prev_r <= evt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lead trigger: edge select and event prescaler; n of zero acts as one

  assign edge_hit = ctrl_r[`PEST_CTRL_FALL] ? (evt_prev_r && !evt_r)
                                            : (!evt_prev_r && evt_r); // see RQ10
  assign presc_wrap = (presc_r == '0) || (presc_cnt_r >= presc_r - 1'b1);

  always_ff @(posedge clock) begin
    if (rst) begin
      presc_cnt_r <= '0;
      lead_fire_r <= 1'b0;
    end else if (ce) begin
      lead_fire_r <= 1'b0;
      if (en && !node && edge_hit) begin
        if (presc_wrap) begin // see RQ2
          presc_cnt_r <= '0;
          lead_fire_r <= 1'b1; // see RQ1
        end else begin
          presc_cnt_r <= presc_cnt_r + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // node side: forward at once, start delay on the same strobe

  assign dly_start = en && node && ping_rx;

  always_ff @(posedge clock) begin
    if (rst) begin
      fwd_r <= 1'b0;
    end else if (ce) begin
      fwd_r <= dly_start; // see RQ8
    end
  end

  pest_delay #(.W(CW)) u_delay (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .start(dly_start),
    .match(match_r),
    .sync_pulse(dly_pulse),
    .count(dly_count),
    .busy(dly_busy)
  );

  // one flop stage on the trigger costs a cycle but keeps outputs clean
  always_ff @(posedge clock) begin
    if (rst) begin
      trig_r <= 1'b0;
      xbar_r <= 1'b0;
    end else if (ce) begin
      trig_r <= (lead_fire_r || fwd_r) && !ctrl_r[`PEST_CTRL_XBAR]; // see RQ7
      xbar_r <= (lead_fire_r || fwd_r) && ctrl_r[`PEST_CTRL_XBAR]; // see RQ7
    end
  end

  assign tx_trigger = trig_r;
  assign crossbar_trigger = xbar_r;
  assign sync_in = dly_pulse;
  assign pwm_output_a = pa_r;
  assign pwm_output_b = pb_r;
  assign pwm_compare_c_event = evt_r;
  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dcb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_fwd_path;
    ce && dly_start ##1 ce;
  endsequence

  a_fwd_immediate: assert property (s_fwd_path |=> (trig_r || xbar_r)) // see RQ8
    else $error("received ping not forwarded in two cycles");
  a_trig_single: assert property (ce && trig_r && !lead_fire_r && !fwd_r |=> !trig_r) // see RQ11
    else $error("trigger longer than one cycle");
  a_route_excl: assert property (!(trig_r && xbar_r)) // see RQ7
    else $error("trigger on both routes");
  a_lead_cause: assert property ($rose(lead_fire_r) |-> $past(edge_hit) && $past(presc_wrap)) // see RQ1
    else $error("lead trigger without prescaled edge");
  // a smaller n written mid-count may leave the count above n until the next edge wraps it
  a_presc_bound: assert property (presc_r != '0 && $stable(presc_r) && $past(presc_cnt_r) < presc_r
                                  |-> presc_cnt_r < presc_r) // see RQ2
    else $error("prescaler count past n");
  a_sync_reload: assert property (ce && dly_pulse |=> cnt_r == '0) // see RQ5
    else $error("sync-in did not reload timebase");
  a_node_quiet: assert property (node |-> !lead_fire_r || !$past(node)) // see RQ1
    else $error("lead trigger fired in node mode");

endmodule // pest_top
